/* File: rtl/dsw_drive_words_regs.vh */
// constants for the drive status and control word block
`ifndef DSW_DRIVE_WORDS_REGS_VH
`define DSW_DRIVE_WORDS_REGS_VH

`define DSW_WORD_W 16
`define DSW_SOL_W 4
`define DSW_DDS_W 2
`define DSW_SOL_MISS_LIMIT 3

// control word one bit positions
`define DSW_CW1_ON 0
`define DSW_CW1_NO_COAST 1
`define DSW_CW1_NO_QUICK 2
`define DSW_CW1_ENABLE_OP 3
`define DSW_CW1_FAULT_ACK 7

// status word one bit positions
`define DSW_SW1_READY_START 0
`define DSW_SW1_READY 1
`define DSW_SW1_OP_ENABLED 2
`define DSW_SW1_FAULT 3
`define DSW_SW1_NO_COAST 4
`define DSW_SW1_NO_QUICK 5
`define DSW_SW1_LOCKOUT 6
`define DSW_SW1_WARNING 7
`define DSW_SW1_SPEED_IN_TOL 8
`define DSW_SW1_MASTER_REQ 9
`define DSW_SW1_SPEED_REACHED 10
`define DSW_SW1_LIMIT_REACHED 11
`define DSW_SW1_BRAKE_OPEN 12
`define DSW_SW1_NO_MOTOR_OVERTEMP 13
`define DSW_SW1_CLOCKWISE 14
`define DSW_SW1_RESET 16'h0000

// control word two fields
`define DSW_CW2_DDS_LSB 0
`define DSW_CW2_PARKING 7
`define DSW_CW2_FIXED_STOP 8
`define DSW_CW2_SOL_LSB 12

// status word two fields
`define DSW_SW2_DDS_LSB 0
`define DSW_SW2_WARN_CLASS_LSB 5
`define DSW_SW2_FIXED_STOP 8
`define DSW_SW2_PULSES_ON 10
`define DSW_SW2_SOL_LSB 12
`define DSW_SW2_RESET 16'h0000

`endif

/* File: rtl/dsw_sign_of_life.v */
// sign-of-life generator and master counter monitor
`timescale 1ns/1ps
`include "dsw_drive_words_regs.vh"

module dsw_sign_of_life #(
    parameter [3:0] MISS_LIMIT = `DSW_SOL_MISS_LIMIT
) (
    input wire clk_sys_i,
    input wire rst_n_i,
    input wire bus_cycle_i,
    input wire [`DSW_SOL_W-1:0] master_sol_i,
    output reg [`DSW_SOL_W-1:0] slave_sol_o,
    output reg [`DSW_SOL_W-1:0] master_sol_o,
    output reg comm_fault_o
);

reg [3:0] miss_cnt;
wire stalled = (master_sol_i == master_sol_o);

always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
        slave_sol_o <= 4'h0;
        master_sol_o <= 4'h0;
        miss_cnt <= 4'h0;
        comm_fault_o <= 1'b0;
    end else if (bus_cycle_i) begin
        // wraps modulo 16 by width
        slave_sol_o <= slave_sol_o + 4'h1;
        master_sol_o <= master_sol_i;
        if (stalled) begin
            // saturate so a long stall does not wrap back to healthy
            if (miss_cnt != 4'hF)
                miss_cnt <= miss_cnt + 4'h1;
            if (miss_cnt + 4'h1 >= MISS_LIMIT)
                comm_fault_o <= 1'b1;
        end else begin
            miss_cnt <= 4'h0;
            comm_fault_o <= 1'b0;
        end
    end
end

endmodule // dsw_sign_of_life

/* File: rtl/dsw_drive_words.v */
// drive status word assembly and control word decode
`timescale 1ns/1ps
`include "dsw_drive_words_regs.vh"

module dsw_drive_words #(
    parameter [3:0] SOL_MISS_LIMIT = `DSW_SOL_MISS_LIMIT
) (
    input wire clk_sys_i,
    input wire rst_n_i,
    input wire bus_cycle_i,
    input wire [15:0] drive_control_word_one_i,
    input wire [15:0] drive_control_word_two_i,
    input wire supply_on_i,
    input wire init_done_i,
    input wire fault_event_i,
    input wire warning_active_i,
    input wire [1:0] warning_class_i,
    input wire signed [15:0] speed_setpoint_i,
    input wire signed [15:0] speed_actual_i,
    input wire [15:0] speed_tolerance_i,
    input wire [15:0] compare_speed_i,
    input wire torque_limit_i,
    input wire current_limit_i,
    input wire telegram_20_i,
    input wire brake_open_i,
    input wire motor_overtemp_i,
    input wire master_control_req_i,
    input wire fixed_stop_active_i,
    output reg [15:0] drive_status_word_one_o,
    output reg [15:0] drive_status_word_two_o,
    output reg [1:0] drive_data_set_o,
    output reg parking_axis_o,
    output reg fixed_stop_enable_o,
    output wire [3:0] master_sol_o,
    output wire comm_fault_o,
    output reg pulses_enable_o
);

localparam [2:0] ST_LOCKOUT = 3'h0;
localparam [2:0] ST_READY_START = 3'h1;
localparam [2:0] ST_READY = 3'h2;
localparam [2:0] ST_OPERATE = 3'h3;
localparam [2:0] ST_FAULT = 3'h4;

reg [2:0] state;
reg [2:0] next_state;
reg [15:0] cw1_prev;
reg fault_pending;
reg next_fault_pending;
reg clockwise;
reg brake_assign_kept;
reg [15:0] next_sw1;
reg [15:0] next_sw2;

wire [3:0] slave_sol;
wire comm_fault;

wire on_cmd = drive_control_word_one_i[`DSW_CW1_ON];
wire no_coast = drive_control_word_one_i[`DSW_CW1_NO_COAST];
wire no_quick = drive_control_word_one_i[`DSW_CW1_NO_QUICK];
wire en_op = drive_control_word_one_i[`DSW_CW1_ENABLE_OP];
wire stop_req = ~no_coast | ~no_quick;

// edges are judged between successive bus cycles, not clocks
wire on_rise = on_cmd & ~cw1_prev[`DSW_CW1_ON];
wire ack_rise = drive_control_word_one_i[`DSW_CW1_FAULT_ACK]
    & ~cw1_prev[`DSW_CW1_FAULT_ACK];
// only a reported fault may be acknowledged, else the state and bit 3 part ways
wire ack_take = bus_cycle_i & ack_rise & (state == ST_FAULT);
wire fault_now = fault_event_i | comm_fault;

// one extra bit so the difference never overflows
wire signed [16:0] speed_diff = {speed_setpoint_i[15], speed_setpoint_i}
    - {speed_actual_i[15], speed_actual_i};
wire [16:0] diff_abs = speed_diff[16] ? (17'h00000 - speed_diff) : speed_diff;
wire [16:0] act_abs = speed_actual_i[15]
    ? (17'h00000 - {speed_actual_i[15], speed_actual_i})
    : {1'b0, speed_actual_i};
wire in_tol = diff_abs <= {1'b0, speed_tolerance_i};
wire speed_reached = act_abs >= {1'b0, compare_speed_i};
wire ready_start_ok = supply_on_i & init_done_i;

dsw_sign_of_life #(
    .MISS_LIMIT(SOL_MISS_LIMIT)
) u_sol (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .bus_cycle_i(bus_cycle_i),
    .master_sol_i(drive_control_word_two_i[`DSW_CW2_SOL_LSB +: 4]),
    .slave_sol_o(slave_sol),
    .master_sol_o(master_sol_o),
    .comm_fault_o(comm_fault)
);

assign comm_fault_o = comm_fault;

// fault latch: a new fault in the ack cycle wins over the ack
always @* begin
    next_fault_pending = fault_pending;
    if (ack_take)
        next_fault_pending = 1'b0;
    if (fault_now)
        next_fault_pending = 1'b1;
end

always @* begin
    next_state = state;
    case (state)
        ST_FAULT: begin
            if (ack_rise && !fault_now) begin
                if (on_cmd)
                    next_state = ST_LOCKOUT;
                else
                    next_state = ST_READY_START;
            end
        end
        ST_LOCKOUT: begin
            if (fault_pending)
                next_state = ST_FAULT;
            else if (!on_cmd && !stop_req)
                next_state = ST_READY_START;
        end
        ST_READY_START: begin
            if (fault_pending)
                next_state = ST_FAULT;
            else if (stop_req)
                next_state = ST_LOCKOUT;
            else if (on_rise && ready_start_ok) begin
                if (en_op)
                    next_state = ST_OPERATE;
                else
                    next_state = ST_READY;
            end
        end
        ST_READY: begin
            if (fault_pending)
                next_state = ST_FAULT;
            else if (stop_req)
                next_state = ST_LOCKOUT;
            else if (!on_cmd)
                next_state = ST_READY_START;
            else if (en_op)
                next_state = ST_OPERATE;
        end
        ST_OPERATE: begin
            if (fault_pending)
                next_state = ST_FAULT;
            else if (stop_req)
                next_state = ST_LOCKOUT;
            else if (!on_cmd)
                next_state = ST_READY_START;
            else if (!en_op)
                next_state = ST_READY;
        end
        default: next_state = ST_LOCKOUT;
    endcase
end

// status word one from the state held before this bus cycle
always @* begin
    next_sw1 = 16'h0000;
    next_sw1[`DSW_SW1_READY_START] = (state == ST_READY_START)
        & ready_start_ok;
    next_sw1[`DSW_SW1_READY] = ((state == ST_READY) | (state == ST_OPERATE))
        & on_cmd & ~fault_pending;
    next_sw1[`DSW_SW1_OP_ENABLED] = (state == ST_OPERATE);
    next_sw1[`DSW_SW1_FAULT] = fault_pending;
    next_sw1[`DSW_SW1_NO_COAST] = no_coast;
    next_sw1[`DSW_SW1_NO_QUICK] = no_quick;
    next_sw1[`DSW_SW1_LOCKOUT] = (state == ST_LOCKOUT);
    next_sw1[`DSW_SW1_WARNING] = warning_active_i;
    next_sw1[`DSW_SW1_SPEED_IN_TOL] = in_tol;
    next_sw1[`DSW_SW1_MASTER_REQ] = master_control_req_i;
    next_sw1[`DSW_SW1_SPEED_REACHED] = speed_reached;
    next_sw1[`DSW_SW1_LIMIT_REACHED] = telegram_20_i
        ? (current_limit_i | torque_limit_i) : torque_limit_i;
    // in telegram 20 the brake signal stays only if it was mapped before
    next_sw1[`DSW_SW1_BRAKE_OPEN] = (~telegram_20_i | brake_assign_kept)
        & brake_open_i;
    next_sw1[`DSW_SW1_NO_MOTOR_OVERTEMP] = ~motor_overtemp_i;
    next_sw1[`DSW_SW1_CLOCKWISE] = clockwise;
end

// bits 0-11 vendor fields, 12-15 profile counter
always @* begin
    next_sw2 = 16'h0000;
    next_sw2[`DSW_SW2_DDS_LSB +: 2] = drive_data_set_o;
    next_sw2[`DSW_SW2_WARN_CLASS_LSB +: 2] = warning_class_i;
    next_sw2[`DSW_SW2_FIXED_STOP] = fixed_stop_active_i;
    next_sw2[`DSW_SW2_PULSES_ON] = (state == ST_OPERATE);
    next_sw2[`DSW_SW2_SOL_LSB +: 4] = slave_sol;
end

always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
        fault_pending <= 1'b0;
    end else begin
        // faults may arrive between bus cycles and must not be missed
        fault_pending <= next_fault_pending;
    end
end

always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
        state <= ST_LOCKOUT;
        cw1_prev <= 16'h0000;
        clockwise <= 1'b0;
        brake_assign_kept <= 1'b0;
        drive_status_word_one_o <= `DSW_SW1_RESET;
        drive_status_word_two_o <= `DSW_SW2_RESET;
        drive_data_set_o <= 2'h0;
        parking_axis_o <= 1'b0;
        fixed_stop_enable_o <= 1'b0;
        pulses_enable_o <= 1'b0;
    end else if (bus_cycle_i) begin
        state <= next_state;
        cw1_prev <= drive_control_word_one_i;
        // zero speed keeps the last direction
        if (speed_actual_i > 16'sh0000)
            clockwise <= 1'b1;
        else if (speed_actual_i < 16'sh0000)
            clockwise <= 1'b0;
        if (!telegram_20_i)
            brake_assign_kept <= 1'b1;
        drive_status_word_one_o <= next_sw1;
        drive_status_word_two_o <= next_sw2;
        // reserved control bits 2-6 and 9-11 are ignored
        drive_data_set_o <= drive_control_word_two_i[`DSW_CW2_DDS_LSB +: 2];
        parking_axis_o <= drive_control_word_two_i[`DSW_CW2_PARKING];
        fixed_stop_enable_o <= drive_control_word_two_i[`DSW_CW2_FIXED_STOP];
        pulses_enable_o <= (next_state == ST_OPERATE);
    end
end

endmodule // dsw_drive_words

/* File: verification/dsw_drive_words_sva.sv */
// checker for the drive status and control word block
`timescale 1ns/1ps
module dsw_drive_words_sva (
    input wire clk_sys_i,
    input wire rst_n_i,
    input wire bus_cycle_i,
    input wire [15:0] drive_control_word_two_i,
    input wire warning_active_i,
    input wire [1:0] warning_class_i,
    input wire motor_overtemp_i,
    input wire master_control_req_i,
    input wire fixed_stop_active_i,
    input wire [15:0] drive_status_word_one_o,
    input wire [15:0] drive_status_word_two_o,
    input wire [1:0] drive_data_set_o,
    input wire parking_axis_o,
    input wire fixed_stop_enable_o,
    input wire [3:0] master_sol_o,
    input wire comm_fault_o,
    input wire pulses_enable_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    overtemp_bit_a: assert property (bus_cycle_i |=>
        drive_status_word_one_o[13] == !$past(motor_overtemp_i))
        else $error("overtemp bit wrong");
    warning_bit_a: assert property (bus_cycle_i |=>
        drive_status_word_one_o[7] == $past(warning_active_i))
        else $error("warning bit wrong");
    master_req_a: assert property (bus_cycle_i |=>
        drive_status_word_one_o[9] == $past(master_control_req_i))
        else $error("master request bit wrong");
    warn_class_a: assert property (bus_cycle_i |=>
        drive_status_word_two_o[6:5] == $past(warning_class_i))
        else $error("warning class wrong");
    fixed_stop_a: assert property (bus_cycle_i |=>
        drive_status_word_two_o[8] == $past(fixed_stop_active_i))
        else $error("fixed stop bit wrong");
    word_two_decode_a: assert property (bus_cycle_i |=>
        {fixed_stop_enable_o, parking_axis_o, drive_data_set_o}
        == $past({drive_control_word_two_i[8:7], drive_control_word_two_i[1:0]}))
        else $error("control two decode wrong");
    master_count_a: assert property (bus_cycle_i |=>
        master_sol_o == $past(drive_control_word_two_i[15:12]))
        else $error("master counter not routed");
    own_count_step_a: assert property (bus_cycle_i ##1 bus_cycle_i |=>
        drive_status_word_two_o[15:12] == $past(drive_status_word_two_o[15:12]) + 4'h1)
        else $error("own counter did not step");
    pulses_bit_a: assert property (bus_cycle_i |=>
        drive_status_word_two_o[10] == $past(pulses_enable_o))
        else $error("pulses bit wrong");
    words_hold_a: assert property (!bus_cycle_i |=>
        $stable(drive_status_word_one_o) && $stable(drive_status_word_two_o))
        else $error("status changed between strobes");
    cover property (bus_cycle_i && pulses_enable_o);
    cover property (bus_cycle_i && drive_status_word_one_o[3]);
    cover property ($rose(comm_fault_o));
endmodule // dsw_drive_words_sva

bind dsw_drive_words dsw_drive_words_sva i_dsw_drive_words_sva (.*);

/* File: verification/dsw_master_model.sv */
// fieldbus master model: bus strobes and master sign-of-life
`timescale 1ns/1ps
module dsw_master_model (
    input wire clk_i,
    input wire rst_n_i,
    input wire slow_i,
    input wire freeze_i,
    output reg bus_cycle_o = 1'b0,
    output reg [3:0] sol_o = 4'h0
);
    // slow mode strobes every second cycle only
    always @(posedge clk_i) begin
        bus_cycle_o <= #1 rst_n_i && (!slow_i || !bus_cycle_o);
        if (bus_cycle_o && !freeze_i) begin
            sol_o <= #1 sol_o + 4'h1;
        end
    end
endmodule // dsw_master_model

/* File: verification/tb.sv */
// testbench for the drive status and control word block
`timescale 1ns/1ps
module tb;
    reg clk = 1'b0, rst_n = 1'b0, slow = 1'b0, fz = 1'b0;
    reg sup = 1'b1, ini = 1'b1, flt = 1'b0, wrn = 1'b0, tq = 1'b0, cur = 1'b0;
    reg t20 = 1'b0, brk = 1'b0, ot = 1'b0, mreq = 1'b0, fsa = 1'b0;
    reg [1:0] wcl = 2'h0;
    reg [15:0] cw1 = 16'h0000, tol = 16'h0005, cmp = 16'h00C8;
    reg [11:0] cw2 = 12'h000;
    reg signed [15:0] sp = 16'h0064, act = 16'h0064;
    reg [3:0] s;
    wire bc, park, fse, cf, pe;
    wire [3:0] msol, msol_o;
    wire [15:0] sw1, sw2;
    wire [1:0] drive_data_set;
    integer miscompares = 0, n_tests = 0, i;
    dsw_master_model i_dsw_master_model (.clk_i(clk), .rst_n_i(rst_n), .slow_i(slow),
        .freeze_i(fz), .bus_cycle_o(bc), .sol_o(msol));
    dsw_drive_words #(.SOL_MISS_LIMIT(4'h3)) i_dsw_drive_words (.clk_sys_i(clk),
        .rst_n_i(rst_n), .bus_cycle_i(bc), .drive_control_word_one_i(cw1),
        .drive_control_word_two_i({msol, cw2}), .supply_on_i(sup), .init_done_i(ini),
        .fault_event_i(flt), .warning_active_i(wrn), .warning_class_i(wcl),
        .speed_setpoint_i(sp), .speed_actual_i(act), .speed_tolerance_i(tol),
        .compare_speed_i(cmp), .torque_limit_i(tq), .current_limit_i(cur),
        .telegram_20_i(t20), .brake_open_i(brk), .motor_overtemp_i(ot),
        .master_control_req_i(mreq), .fixed_stop_active_i(fsa),
        .drive_status_word_one_o(sw1), .drive_status_word_two_o(sw2),
        .drive_data_set_o(drive_data_set), .parking_axis_o(park), .fixed_stop_enable_o(fse),
        .master_sol_o(msol_o), .comm_fault_o(cf), .pulses_enable_o(pe));
    initial begin
        forever #50 clk = ~clk;
    end
    task chk(input [15:0] got, input [15:0] exp);
        begin
            n_tests = n_tests + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("ERROR %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task step(input integer n);
        begin
            repeat (n) @(posedge clk);
            #1;
        end
    endtask
    task end_of_test;
        begin
            if (miscompares == 0 && n_tests > 0) begin
                $display("verification passed");
            end else begin
                $display("verification failed");
            end
            $finish;
        end
    endtask
    task t_states;
        begin
            cw1 = 16'h0006;
            step(4);
            chk(sw1, 16'h6131);
            cw1 = 16'h000F;
            step(1);
            chk(pe, 1'b1);
            step(2);
            chk(sw1, 16'h6136);
            chk(sw2[10], 1'b1);
            cw1 = 16'h0007;
            step(3);
            chk(sw1 & 16'hFFFE, 16'h6132);
            cw1 = 16'h0005;
            step(3);
            chk(sw1[6:4], 3'h6);
            cw1 = 16'h0003;
            step(3);
            chk(sw1[5], 1'b0);
            cw1 = 16'h0006;
            step(4);
            chk(sw1[6], 1'b0);
        end
    endtask
    task t_fault;
        begin
            cw1 = 16'h0007;
            step(3);
            flt = 1'b1;
            step(1);
            flt = 1'b0;
            step(3);
            chk(sw1[3:1], 3'h4);
            cw1 = 16'h0087;
            step(3);
            chk(sw1[6:3], 4'hE);
            cw1 = 16'h0006;
            step(4);
            chk(sw1[0], 1'b1);
            ini = 1'b0;
            step(2);
            chk(sw1[0], 1'b0);
            ini = 1'b1;
        end
    endtask
    task t_inputs;
        begin
            for (i = 0; i < 4; i = i + 1) begin
                wrn = i[0];
                wcl = i[1:0];
                ot = i[1];
                mreq = i[0];
                fsa = i[1];
                cw2 = {3'h0, i[1], i[0], 5'h00, i[1:0]};
                step(3);
                chk({sw1[13], sw1[9], sw1[7]}, {!i[1], i[0], i[0]});
                chk({sw2[8], sw2[6:5], sw2[1:0]}, {i[1], i[1:0], i[1:0]});
                chk({fse, park, drive_data_set}, {i[1], i[0], i[1:0]});
            end
            act = 16'hFF38;
            sp = 16'hFF3D;
            step(2);
            chk({sw1[14], sw1[10], sw1[8]}, 3'h3);
            tol = 16'h0004;
            cmp = 16'h00C9;
            step(2);
            chk({sw1[10], sw1[8]}, 2'h0);
            cur = 1'b1;
            brk = 1'b1;
            step(2);
            chk(sw1[12:11], 2'h2);
            t20 = 1'b1;
            step(2);
            chk(sw1[12:11], 2'h3);
            {t20, cur, tq} = 3'h1;
            step(2);
            chk(sw1[11], 1'b1);
        end
    endtask
    task t_life;
        begin
            s = sw2[15:12] + 4'h1;
            step(1);
            chk(sw2[15:12], s);
            slow = 1'b1;
            fz = 1'b1;
            step(12);
            chk({cf, sw1[3]}, 2'h3);
            chk(msol_o, msol);
            fz = 1'b0;
            step(4);
            chk(cf, 1'b0);
        end
    endtask
    initial begin
        #(5000 * 100);
        miscompares = miscompares + 1;
        end_of_test;
    end
    initial begin
        step(6);
        chk(sw2, 16'h0000);
        rst_n = 1'b1;
        t_states;
        t_fault;
        t_inputs;
        t_life;
        end_of_test;
    end
endmodule // tb
